// >>> design/bst_regs.vh
// Encoding constants and layout for the bit set and bit test skip decoder
`ifndef BST_REGS_VH
`define BST_REGS_VH
// ==========================================================
// Instruction word layout
`define BST_INSTR_W 12
`define BST_OPC_HI 11
`define BST_OPC_LO 8
`define BST_BIT_HI 7
`define BST_BIT_LO 5
`define BST_FILE_HI 4
`define BST_FILE_LO 0
// ==========================================================
// Opcodes
`define BST_OPC_BIT_SET 4'h5
`define BST_OPC_SKIP_CLR 4'h6
`define BST_OPC_SKIP_SET 4'h7
// ==========================================================
// Reset values
`define BST_FILE_RESET 8'h00
`define BST_INSTR_RESET 12'h000
`endif

// >>> design/bst_file_mem.v
// Small file-register memory with registered read data
`timescale 1ns/100ps
module bst_file_mem #(
	parameter AW = 5,
	parameter DW = 8
) (
	// Clock
	input wire mclk,
	// Read port
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data,
	// Write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		// Write-through keeps a read of the word just written coherent
		if (wr_en && (wr_addr == rd_addr)) begin
			rd_data <= wr_data;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // bst_file_mem

// >>> design/bst_core.v
// Decode and execute stage for bit set and bit test skip instructions
//
// Contract
// - The bit set opcode writes one into the chosen bit of the addressed file register, touches no flag and takes one cycle.
// - Each instruction is a 12-bit word of 4-bit opcode, 3-bit bit select and 5-bit file address.
// - The skip-if-clear opcode skips the next instruction only when the chosen bit is zero, flags untouched.
// - The skip-if-set opcode skips the next instruction only when the chosen bit is one, flags untouched.
`timescale 1ns/100ps
`include "bst_regs.vh"
module bst_core #(
	parameter FILE_AW = 5,
	parameter DATA_W = 8
) (
	// Clock and reset
	input wire mclk,
	input wire resetn,
	// Instruction from the fetch pipeline, one per cycle when valid
	input wire instr_valid,
	input wire [`BST_INSTR_W-1:0] instr_word,
	// Debug read of the file registers
	input wire [FILE_AW-1:0] dbg_addr,
	// Execute results
	output reg exec_valid_r,
	output reg skip_nop_r,
	output reg unknown_op_r,
	output reg [`BST_INSTR_W-1:0] exec_word_r,
	output reg [DATA_W-1:0] dbg_data_r
);
	// ==========================================================
	// Field decode
	function [3:0] f_opc;
		input [`BST_INSTR_W-1:0] w;
		f_opc = w[`BST_OPC_HI:`BST_OPC_LO];
	endfunction

	function [DATA_W-1:0] f_mask;
		input [`BST_INSTR_W-1:0] w;
		f_mask = {{(DATA_W-1){1'b0}}, 1'b1} << w[`BST_BIT_HI:`BST_BIT_LO];
	endfunction

	function [FILE_AW-1:0] f_file;
		input [`BST_INSTR_W-1:0] w;
		f_file = w[`BST_FILE_HI:`BST_FILE_LO];
	endfunction

	// Only three opcodes belong to this stage; anything else retires with no effect
	function f_known;
		input [3:0] op;
		f_known = (op == `BST_OPC_BIT_SET) || (op == `BST_OPC_SKIP_CLR) ||
			(op == `BST_OPC_SKIP_SET);
	endfunction

	// Bit picked out of a file register value by the bit select field
	function f_bit;
		input [DATA_W-1:0] d;
		input [`BST_INSTR_W-1:0] w;
		f_bit = |(d & f_mask(w));
	endfunction

	// ==========================================================
	// Pipeline: stage 1 reads the file, stage 2 executes
	localparam ST_RUN = 1'b0;
	localparam ST_FLUSH = 1'b1;
	localparam NUM_FILES = 1 << FILE_AW;

	reg state_r;
	reg state_nxt;
	reg s2_valid_r;
	reg [`BST_INSTR_W-1:0] s2_word_r;
	reg [FILE_AW-1:0] wr_addr;
	reg [DATA_W-1:0] wr_data;
	reg wr_en;
	reg take_skip;
	reg bit_val;
	wire [DATA_W-1:0] rd_data;
	wire [FILE_AW-1:0] rd_addr;
	wire [3:0] s2_opc;
	// One flag per file register, set once the register has been written since reset
	reg [NUM_FILES-1:0] written_r;
	reg rd_ok_r;
	wire [DATA_W-1:0] file_data;

	assign rd_addr = f_file(instr_word);
	assign s2_opc = f_opc(s2_word_r);
	// The memory array has no reset, so an unwritten register reads as its reset value
	assign file_data = rd_ok_r ? rd_data : `BST_FILE_RESET;

	bst_file_mem #(
		.AW(FILE_AW),
		.DW(DATA_W)
	) u_mem (
		.mclk(mclk),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	// ==========================================================
	// Execute stage
	// A set writes the whole register back with one bit forced high; other bits pass unchanged
	always @* begin
		wr_en = 1'b0;
		take_skip = 1'b0;
		wr_addr = f_file(s2_word_r);
		bit_val = f_bit(file_data, s2_word_r);
		wr_data = file_data | f_mask(s2_word_r);
		if (s2_valid_r && state_r == ST_RUN) begin
			case (s2_opc)
				`BST_OPC_BIT_SET: begin
					wr_en = 1'b1;
				end
				`BST_OPC_SKIP_CLR: begin
					take_skip = ~bit_val;
				end
				`BST_OPC_SKIP_SET: begin
					take_skip = bit_val;
				end
				default: begin
					take_skip = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Skip sequencer
	// A taken test parks here for one slot; the word in stage 2 during that slot is dropped
	always @* begin
		state_nxt = ST_RUN;
		case (state_r)
			ST_RUN: begin
				if (take_skip) begin
					state_nxt = ST_FLUSH;
				end
			end
			ST_FLUSH: begin
				state_nxt = ST_RUN;
			end
			default: begin
				// Unused code falls back to normal running
				state_nxt = ST_RUN;
			end
		endcase
	end

	// ==========================================================
	// Pipeline registers
	// Stage 1 samples the word at the same edge as the memory read of its file register
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_RUN;
			s2_valid_r <= 1'b0;
			s2_word_r <= `BST_INSTR_RESET;
		end else begin
			state_r <= state_nxt;
			s2_valid_r <= instr_valid;
			s2_word_r <= instr_word;
		end
	end

	// ==========================================================
	// Retire outputs
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			exec_valid_r <= 1'b0;
			skip_nop_r <= 1'b0;
			unknown_op_r <= 1'b0;
			exec_word_r <= `BST_INSTR_RESET;
		end else begin
			// Flush cycle retires the prefetched word as a no-operation
			exec_valid_r <= s2_valid_r;
			skip_nop_r <= s2_valid_r && (state_r == ST_FLUSH);
			exec_word_r <= (state_r == ST_FLUSH) ? `BST_INSTR_RESET : s2_word_r;
			// Unknown words retire but change nothing
			unknown_op_r <= s2_valid_r && (state_r == ST_RUN) && !f_known(s2_opc);
		end
	end

	// ==========================================================
	// File register valid tracking
	// Cheaper than clearing every word on reset: a flag per word masks stale array contents
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			written_r <= {NUM_FILES{1'b0}};
			rd_ok_r <= 1'b0;
		end else begin
			if (wr_en) begin
				written_r[wr_addr] <= 1'b1;
			end
			// Mirrors the write-through of the memory so the flag and the data agree
			rd_ok_r <= written_r[rd_addr] || (wr_en && (wr_addr == rd_addr));
		end
	end

	// ==========================================================
	// Debug read port
	// A shadow copy serves the debug port without a second read port on the memory;
	// it costs a register per word but keeps the memory a plain one-read one-write array
	reg [DATA_W-1:0] shadow [0:NUM_FILES-1];
	integer i;

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < NUM_FILES; i = i + 1) begin
				shadow[i] <= `BST_FILE_RESET;
			end
			dbg_data_r <= `BST_FILE_RESET;
		end else begin
			if (wr_en) begin
				shadow[wr_addr] <= wr_data;
			end
			// Shadow and memory take the same write, so both agree on every register written since reset
			dbg_data_r <= shadow[dbg_addr];
		end
	end
endmodule // bst_core

// >>> verif/bst_fetch_model.sv
// Fetch pipeline model that offers one word per issue
`timescale 1ns/100ps
module bst_fetch_model (
	// Clock
	input wire mclk,
	// Offered instruction
	output reg instr_valid,
	output reg [11:0] instr_word
);
initial begin
	instr_valid = 1'b0;
	instr_word = 12'h000;
end
task issue(input [11:0] w);
begin
	@(posedge mclk);
	instr_valid <= 1'b1;
	instr_word <= w;
end
endtask
// Idle word flips so a stale value never looks valid
task idle;
begin
	@(posedge mclk);
	instr_valid <= 1'b0;
	instr_word <= ~instr_word;
end
endtask
endmodule // bst_fetch_model

// >>> verif/bst_core_props.sv
// Checker for the bit set and bit test skip stage
`timescale 1ns/100ps
module bst_core_props (
	// Watched ports
	input wire mclk,
	input wire resetn,
	input wire instr_valid,
	input wire [11:0] instr_word,
	input wire exec_valid_r,
	input wire skip_nop_r,
	input wire [11:0] exec_word_r
);
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
// ==========================================
// Properties
a_retire_two: assert property (instr_valid |-> ##2 exec_valid_r)
	else $error("retire late");
a_word_pass: assert property (exec_valid_r && !skip_nop_r |->
	exec_word_r == $past(instr_word, 2)) else $error("retired word wrong");
a_set_noskip: assert property (exec_valid_r && exec_word_r[11:8] == 4'h5 |=>
	!skip_nop_r) else $error("set caused skip");
a_skip_cause: assert property (skip_nop_r |->
	$past(exec_word_r[11:9]) == 3'b011) else $error("skip without test");
a_nop_word: assert property (skip_nop_r |->
	exec_valid_r && exec_word_r == 12'h000) else $error("flushed slot wrong");
endmodule // bst_core_props
bind bst_core bst_core_props u_props (.mclk, .resetn, .instr_valid, .instr_word,
	.exec_valid_r, .skip_nop_r, .exec_word_r);

// >>> verif/bst_core_tb.sv
// Testbench for the bit set and bit test skip stage
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %0t mismatch", $time); end end
module bst_core_tb;
reg mclk = 0;
reg resetn = 0;
reg [4:0] dbg_addr = 5'h00;
wire instr_valid, exec_valid_r, skip_nop_r, unknown_op_r;
wire [11:0] instr_word, exec_word_r;
wire [7:0] dbg_data_r;
integer error_cnt = 0, n_tests = 0, n_skip = 0, i;
reg [11:0] tst [0:3];
initial begin
	forever #25 mclk = ~mclk;
end
bst_fetch_model u_fetch (.mclk(mclk), .instr_valid(instr_valid), .instr_word(instr_word));
bst_core u_dut (.mclk(mclk), .resetn(resetn), .instr_valid(instr_valid),
	.instr_word(instr_word), .dbg_addr(dbg_addr), .exec_valid_r(exec_valid_r),
	.skip_nop_r(skip_nop_r), .unknown_op_r(unknown_op_r), .exec_word_r(exec_word_r),
	.dbg_data_r(dbg_data_r));
always @(posedge mclk) if (skip_nop_r === 1'b1) n_skip <= n_skip + 1;
task rd(input [4:0] a);
begin
	@(posedge mclk);
	dbg_addr <= a;
	repeat (3) @(posedge mclk);
	#1;
end
endtask
task t_set;
begin
	u_fetch.issue(12'h5e3);
	u_fetch.issue(12'h51f);
	repeat (5) u_fetch.idle;
	rd(5'd3);
	`CHK(dbg_data_r, 8'h80)
	rd(5'd31);
	`CHK(dbg_data_r, 8'h01)
end
endtask
// Each test is followed by a set on reg 5 that must vanish when skipped
task t_skip;
begin
	tst[0] = 12'h6e3; tst[1] = 12'h7e3; tst[2] = 12'h6c3; tst[3] = 12'h7c3;
	for (i = 0; i < 4; i = i + 1) begin
		u_fetch.issue(tst[i]);
		u_fetch.issue({4'h5, i[2:0], 5'd5});
		u_fetch.idle;
	end
	repeat (4) u_fetch.idle;
	rd(5'd5);
	`CHK(dbg_data_r, 8'h09)
	`CHK(n_skip, 2)
end
endtask
// A word outside the three opcodes retires flagged and leaves the file alone
task t_unknown;
begin
	u_fetch.issue(12'h8e3);
	u_fetch.idle;
	@(posedge mclk);
	#1;
	`CHK(unknown_op_r, 1'b1)
	`CHK(exec_word_r, 12'h8e3)
	`CHK(skip_nop_r, 1'b0)
	@(posedge mclk);
	#1;
	`CHK(unknown_op_r, 1'b0)
	rd(5'd3);
	`CHK(dbg_data_r, 8'h80)
end
endtask
task tally_and_finish;
begin
	$display("errors %0d checks %0d", error_cnt, n_tests);
	if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
	else $display("SIMULATION FAILED");
	$finish;
end
endtask
initial begin
	#20000;
	error_cnt++;
	tally_and_finish;
end
initial begin
	repeat (2) @(posedge mclk);
	resetn <= 1'b1;
	t_set;
	t_skip;
	t_unknown;
	tally_and_finish;
end
endmodule // bst_core_tb
